// ---- core/rsc_pkg.sv ----
package rsc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_GUARD = 4'h0;
    localparam logic [3:0] ADDR_FLAGS = 4'h1;
    localparam logic [3:0] ADDR_THRESH = 4'h2;
    localparam logic [3:0] ADDR_FLASH1 = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
    localparam logic [3:0] ADDR_WDT_STAT = 4'h7;
    // ------------------------------------------------------------
    // codes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] GUARD_OK_A = 8'h55;
    localparam logic [7:0] GUARD_OK_B = 8'hAA;
    localparam logic [7:0] GUARD_POR = 8'h55;
    localparam logic [7:0] THR_1V7 = 8'h66;
    localparam logic [7:0] THR_1V9 = 8'h55;
    localparam logic [7:0] THR_2V55 = 8'h33;
    localparam logic [7:0] THR_3V15 = 8'h99;
    localparam logic [7:0] THR_3V8 = 8'hAA;
    localparam logic [7:0] THR_OFF = 8'hF0;
    localparam logic [7:0] THR_POR = 8'h66;
    localparam logic [7:0] FLASH_RESET_CODE = 8'h55;
    localparam logic [7:0] PORT_POR = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [2:0] SEL_1V7 = 3'h0;
    localparam logic [2:0] SEL_1V9 = 3'h1;
    localparam logic [2:0] SEL_2V55 = 3'h2;
    localparam logic [2:0] SEL_3V15 = 3'h3;
    localparam logic [2:0] SEL_3V8 = 3'h4;
    // ------------------------------------------------------------
    // flag bit positions
    // ------------------------------------------------------------
    localparam int BIT_WDT_CTRL = 0;
    localparam int BIT_THR_FAULT = 1;
    localparam int BIT_LOW_V = 2;
    localparam int BIT_GUARD = 3;
    localparam int BIT_TIMEOUT = 0;
    localparam int BIT_POWER_DOWN = 1;
    // ------------------------------------------------------------
    // timing at 20 MHz
    // ------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int FILTER_NS = 1000;
    localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int SRESET_NS = 2000;
    localparam int SRESET_CYC = (SRESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC = 4;
    localparam logic [7:0] CNT_FILTER = 8'(FILTER_CYC);
    localparam logic [7:0] CNT_SRESET = 8'(SRESET_CYC);
    localparam logic [7:0] CNT_PULSE = 8'(PULSE_CYC);

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DELAY = 2'b01,
        ST_PULSE = 2'b10
    } rsc_state_type;

    typedef struct packed {
        logic full;
        logic wake;
        logic por;
    } rsc_kind_type;
endpackage

// ---- core/rsc_reset_source_control.sv ----
// Operation
// RULE1: power-on clears program counter to zero
// RULE2: power-on sets port data/control to ones
// RULE3: guard codes 55/AA idle, others reset delayed
// RULE4: guard register resets to 55, fully writable
// RULE5: guard reset sets flag bit3, software clears
// RULE6: low-voltage reset off in sleep and idle (code disables it only while sleep_mode is high, not after halt_exec)
// RULE7: low supply must outlast filter time
// RULE8: low-voltage reset sets flag bit2, software clears
// RULE9: threshold codes select level, F0 disables
// RULE10: undefined threshold code resets, restores register
// RULE11: threshold fault sets flag bit1, software clears
// RULE12: real low-voltage reset keeps threshold register
// RULE13: threshold register resets to 66
// RULE14: flag bits 7..4 read zero
// RULE15: writing 55 to flash control resets all
// RULE16: normal watchdog timeout acts as low-voltage, sets flag
// RULE17: sleeping timeout clears counters, sets both flags
// RULE18: watchdog control fault sets flag bit0 (code sets it only when guard and threshold codes are valid at delay end)
// RULE19: software reset delay counter then reset
`timescale 1ns/1ns
`default_nettype none
module rsc_reset_source_control
    import rsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic low_supply,
    input wire logic sleep_mode,
    input wire logic wdt_timeout,
    input wire logic wdt_ctrl_fault,
    input wire logic halt_exec,
    input wire logic clr_wdt,
    output logic lvr_enable,
    output logic [2:0] lvr_level_sel,
    output logic core_reset,
    output logic pc_sp_clear,
    output logic [7:0] port_init,
    output logic port_init_load,
    output logic irq
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic low_meta, low_sync;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            low_meta <= 1'b0;
            low_sync <= 1'b0;
        end else begin
            low_meta <= low_supply;
            low_sync <= low_meta;
        end
    end

    // ------------------------------------------------------------
    // registers and decode
    // ------------------------------------------------------------
    logic [7:0] guard_code_bits;
    logic [7:0] threshold_code_bits;
    logic [3:0] flags;
    logic [1:0] core_status;
    logic [4:0] irq_mask, irq_stat;
    rsc_state_type state;
    rsc_kind_type kind;
    logic [7:0] cnt;
    logic [7:0] lv_cnt;
    logic por_done;
    logic wr_guard, wr_thresh, wr_flags, wr_flash;
    logic guard_bad, thr_bad, lv_fire, wdt_norm, wdt_sleep;
    logic start_delay, start_pulse, thr_restore;
    logic rd_irq;
    logic [4:0] events;

    assign wr_guard = wr_stb && addr == ADDR_GUARD;
    assign wr_thresh = wr_stb && addr == ADDR_THRESH;
    assign wr_flags = wr_stb && addr == ADDR_FLAGS;
    assign wr_flash = wr_stb && addr == ADDR_FLASH1;
    assign rd_irq = rd_stb && addr == ADDR_IRQ_STAT;

    // [RULE3]
    assign guard_bad = guard_code_bits != GUARD_OK_A
        && guard_code_bits != GUARD_OK_B;
    // [RULE9] [RULE10]
    assign thr_bad = !(threshold_code_bits inside {THR_1V7, THR_1V9,
        THR_2V55, THR_3V15, THR_3V8, THR_OFF});

    always_comb begin
        lvr_level_sel = SEL_1V7;
        case (threshold_code_bits) // [RULE9]
            THR_1V9: lvr_level_sel = SEL_1V9;
            THR_2V55: lvr_level_sel = SEL_2V55;
            THR_3V15: lvr_level_sel = SEL_3V15;
            THR_3V8: lvr_level_sel = SEL_3V8;
            default: lvr_level_sel = SEL_1V7;
        endcase
    end

    // [RULE6] detector off while sleeping, or by code F0
    assign lvr_enable = !sleep_mode && !thr_bad
        && threshold_code_bits != THR_OFF;

    // ------------------------------------------------------------
    // low-voltage filter
    // ------------------------------------------------------------
    // a glitch shorter than the filter restarts the count
    always_ff @(posedge ref_clk) begin
        if (rst || !lvr_enable || !low_sync || state != ST_RUN) begin
            lv_cnt <= ZERO8;
        end else if (lv_cnt != CNT_FILTER) begin
            lv_cnt <= lv_cnt + 8'h01;
        end
    end
    assign lv_fire = lvr_enable && low_sync && lv_cnt == CNT_FILTER; // [RULE7]

    assign wdt_norm = wdt_timeout && !sleep_mode; // [RULE16]
    assign wdt_sleep = wdt_timeout && sleep_mode; // [RULE17]
    assign start_delay = state == ST_RUN && por_done
        && (guard_bad || thr_bad || wdt_ctrl_fault);
    assign start_pulse = state == ST_RUN && por_done
        && (lv_fire || wdt_norm || wdt_sleep || wr_flash
        && wdata == FLASH_RESET_CODE); // [RULE15]

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_PULSE;
            cnt <= CNT_PULSE;
            kind <= '{full: 1'b1, wake: 1'b0, por: 1'b1};
            por_done <= 1'b0;
        end else begin
            case (state)
                ST_RUN: begin
                    por_done <= 1'b1;
                    if (start_pulse) begin
                        state <= ST_PULSE;
                        cnt <= CNT_PULSE;
                        kind <= '{full: !wdt_sleep || lv_fire
                            || wr_flash, wake: 1'b1, por: 1'b0};
                    end else if (start_delay) begin
                        state <= ST_DELAY; // [RULE19]
                        cnt <= CNT_SRESET;
                        kind <= '{full: 1'b1, wake: 1'b1, por: 1'b0};
                    end
                end
                ST_DELAY: begin
                    if (cnt == ZERO8) begin
                        state <= ST_PULSE; // [RULE19]
                        cnt <= CNT_PULSE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                ST_PULSE: begin
                    if (cnt == ZERO8) begin
                        state <= ST_RUN;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    assign core_reset = state == ST_PULSE && kind.full;
    assign pc_sp_clear = state == ST_PULSE; // [RULE1] [RULE17]
    assign port_init_load = state == ST_PULSE && kind.full; // [RULE2]
    assign port_init = PORT_POR; // [RULE2]

    // ------------------------------------------------------------
    // guard and threshold registers
    // ------------------------------------------------------------
    logic delay_end;
    assign delay_end = state == ST_DELAY && cnt == ZERO8;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            guard_code_bits <= GUARD_POR; // [RULE4]
        end else if (delay_end && guard_bad) begin
            guard_code_bits <= GUARD_POR;
        end else if (wr_guard) begin
            guard_code_bits <= wdata; // [RULE4]
        end
    end

    // low-voltage and watchdog resets never touch this register
    assign thr_restore = delay_end && thr_bad; // [RULE10] [RULE12]
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            threshold_code_bits <= THR_POR; // [RULE13]
        end else if (thr_restore) begin
            threshold_code_bits <= THR_POR; // [RULE10]
        end else if (wr_thresh) begin
            threshold_code_bits <= wdata;
        end
    end

    // ------------------------------------------------------------
    // reset source flags: set wins over software clear
    // ------------------------------------------------------------
    logic [3:0] flag_set;
    always_comb begin
        flag_set = 4'h0;
        flag_set[BIT_GUARD] = delay_end && guard_bad; // [RULE5]
        flag_set[BIT_LOW_V] = start_pulse && lv_fire; // [RULE8]
        flag_set[BIT_THR_FAULT] = thr_restore; // [RULE11]
        flag_set[BIT_WDT_CTRL] = delay_end && wdt_ctrl_fault
            && !guard_bad && !thr_bad; // [RULE18]
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags <= 4'h0;
        end else if (wr_flags) begin
            flags <= (flags & wdata[3:0]) | flag_set; // [RULE5] [RULE8]
        end else begin
            flags <= flags | flag_set;
        end
    end

    // timeout and power-down status
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            core_status <= 2'h0;
        end else begin
            if (start_pulse && wdt_timeout && !lv_fire) begin
                core_status[BIT_TIMEOUT] <= 1'b1; // [RULE16] [RULE17]
            end else if (clr_wdt) begin
                core_status[BIT_TIMEOUT] <= 1'b0;
            end
            if (start_pulse && wdt_sleep && !lv_fire || halt_exec) begin
                core_status[BIT_POWER_DOWN] <= 1'b1; // [RULE17]
            end else if (clr_wdt) begin
                core_status[BIT_POWER_DOWN] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign events = {start_pulse && wdt_timeout, flag_set};
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_stat <= 5'h00;
        end else if (rd_irq) begin
            irq_stat <= events;
        end else begin
            irq_stat <= irq_stat | events;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_mask <= 5'h00;
        end else if (wr_stb && addr == ADDR_IRQ_MASK) begin
            irq_mask <= wdata[4:0];
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= ZERO8;
        end else if (rd_stb) begin
            case (addr)
                ADDR_GUARD: rdata <= guard_code_bits;
                ADDR_FLAGS: rdata <= {4'h0, flags}; // [RULE14]
                ADDR_THRESH: rdata <= threshold_code_bits;
                ADDR_STATUS: rdata <= {6'h00, core_status};
                ADDR_IRQ_MASK: rdata <= {3'h0, irq_mask};
                ADDR_IRQ_STAT: rdata <= {3'h0, irq_stat};
                ADDR_WDT_STAT: rdata <= {6'h00, state};
                default: rdata <= ZERO8;
            endcase
        end else begin
            rdata <= ZERO8;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // cycles from the first delay cycle to the start of the pulse
    localparam int DELAY_CYC = SRESET_CYC + 1;
    guard_delay_a: assert property ( // [RULE3]
        @(posedge ref_clk) disable iff (rst)
        state == ST_RUN && por_done && guard_bad && !start_pulse
        |=> state == ST_DELAY ##[1:60] core_reset)
        else $error("guard fault did not reset");
    guard_por_a: assert property ( // [RULE4]
        @(posedge ref_clk) $past(rst) |-> guard_code_bits == GUARD_POR)
        else $error("guard reset value wrong");
    guard_idle_a: assert property ( // [RULE3]
        @(posedge ref_clk) disable iff (rst)
        state == ST_RUN && !guard_bad && !thr_bad && !wdt_ctrl_fault
        |=> state != ST_DELAY)
        else $error("good codes started a delay");
    guard_flag_a: assert property ( // [RULE5]
        @(posedge ref_clk) disable iff (rst)
        flag_set[BIT_GUARD] |=> flags[BIT_GUARD])
        else $error("guard flag not set");
    flag_sticky_a: assert property ( // [RULE5] [RULE8] [RULE11] [RULE18]
        @(posedge ref_clk) disable iff (rst)
        ($past(flags) & ~flags) != 4'h0 |-> $past(wr_flags))
        else $error("reset flag cleared without a write");
    lv_filter_a: assert property ( // [RULE7]
        @(posedge ref_clk) disable iff (rst)
        $rose(lv_fire) |-> $past(low_sync, FILTER_CYC))
        else $error("low voltage filter too short");
    sleep_off_a: assert property ( // [RULE6]
        @(posedge ref_clk) disable iff (rst) sleep_mode |-> !lvr_enable)
        else $error("low voltage reset active in sleep");
    thr_restore_a: assert property ( // [RULE10]
        @(posedge ref_clk) disable iff (rst)
        thr_restore |=> threshold_code_bits == THR_POR
        && flags[BIT_THR_FAULT])
        else $error("threshold not restored");
    flag_high_a: assert property ( // [RULE14]
        @(posedge ref_clk) disable iff (rst)
        rd_stb && addr == ADDR_FLAGS |=> rdata[7:4] == 4'h0)
        else $error("flag high bits not zero");
    flash_reset_a: assert property ( // [RULE15]
        @(posedge ref_clk) disable iff (rst)
        start_pulse && wr_flash |=> core_reset [*4])
        else $error("flash code did not reset");
    pulse_len_a: assert property ( // [RULE1]
        @(posedge ref_clk) disable iff (rst)
        $rose(pc_sp_clear) |-> pc_sp_clear [*5] ##1 !pc_sp_clear)
        else $error("reset pulse length wrong");
    port_init_a: assert property ( // [RULE2]
        @(posedge ref_clk) disable iff (rst)
        core_reset |-> pc_sp_clear && port_init_load
        && port_init == PORT_POR)
        else $error("full reset did not load ports");
    wdt_norm_a: assert property ( // [RULE16]
        @(posedge ref_clk) disable iff (rst)
        start_pulse && wdt_norm && !lv_fire
        |=> core_reset && core_status[BIT_TIMEOUT])
        else $error("running timeout did not reset");
    sleep_wake_a: assert property ( // [RULE17]
        @(posedge ref_clk) disable iff (rst)
        start_pulse && wdt_sleep && !lv_fire && !wr_flash
        |=> pc_sp_clear && !core_reset
        && core_status == 2'h3)
        else $error("sleeping timeout wrong");
    lv_keep_a: assert property ( // [RULE12]
        @(posedge ref_clk) disable iff (rst)
        start_pulse && lv_fire && !wr_thresh
        |=> $stable(threshold_code_bits))
        else $error("threshold changed by low voltage");
    delay_len_a: assert property ( // [RULE19]
        @(posedge ref_clk) disable iff (rst)
        $rose(state == ST_DELAY)
        |-> ##[DELAY_CYC:DELAY_CYC] $rose(core_reset))
        else $error("software reset delay length wrong");

    lv_reset_c: cover property (@(posedge ref_clk) disable iff (rst)
        flag_set[BIT_LOW_V]);
    guard_reset_c: cover property (@(posedge ref_clk) disable iff (rst)
        flag_set[BIT_GUARD]);
    wake_c: cover property (@(posedge ref_clk) disable iff (rst)
        start_pulse && wdt_sleep);
    irq_c: cover property (@(posedge ref_clk) disable iff (rst) irq);
    delay_c: cover property (@(posedge ref_clk) disable iff (rst)
        delay_end);
endmodule
`default_nettype wire

// ---- tb/rsc_reset_source_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, got, e) begin check_count++; if ((got) !== (e)) begin \
    error_cnt++; $display("[ERR] %s exp %0h got %0h", nm, e, got); end end
module rsc_reset_source_control_test import rsc_pkg::*;;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic ref_clk, rst, wr_stb, rd_stb, low_supply, sleep_mode;
    logic wdt_timeout, wdt_ctrl_fault, halt_exec, clr_wdt;
    logic lvr_enable, core_reset, pc_sp_clear, port_init_load, irq;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, port_init, v;
    logic [2:0] lvr_level_sel;
    logic i0, i1, wdt_bad_req;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    logic [7:0] codes [5] = '{THR_1V7, THR_1V9, THR_2V55, THR_3V15, THR_3V8};
    logic [2:0] sels [5] = '{SEL_1V7, SEL_1V9, SEL_2V55, SEL_3V15, SEL_3V8};

    rsc_reset_source_control rsc_reset_source_control_i (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .low_supply(low_supply), .sleep_mode(sleep_mode),
        .wdt_timeout(wdt_timeout), .wdt_ctrl_fault(wdt_ctrl_fault),
        .halt_exec(halt_exec), .clr_wdt(clr_wdt),
        .lvr_enable(lvr_enable), .lvr_level_sel(lvr_level_sel),
        .core_reset(core_reset), .pc_sp_clear(pc_sp_clear),
        .port_init(port_init), .port_init_load(port_init_load), .irq(irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // the outside watchdog holds a bad control code until a full reset
    always @(posedge ref_clk) begin
        if (rst === 1'b1 || core_reset === 1'b1) wdt_ctrl_fault <= 1'b0;
        else if (wdt_bad_req === 1'b1) wdt_ctrl_fault <= 1'b1;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // bus and reset tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [7:0] e,
                           input string nm);
        logic [7:0] d;
        rd(a, d);
        `CHK(nm, d, e)
    endtask

    // counts cycles to the full reset, then its length
    task automatic wait_rst(input int lo, input int hi, input string nm);
        int n;
        int m;
        n = 0;
        m = 0;
        #1;
        while (core_reset !== 1'b1 && n <= hi) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK(nm, n >= lo && n <= hi, 1'b1)
        `CHK("init", {pc_sp_clear, port_init_load, port_init}, 10'h3FF)
        while (core_reset === 1'b1 && m < 20) begin
            @(posedge ref_clk);
            #1;
            m++;
        end
        `CHK("pulse_len", m, PULSE_CYC + 1)
    endtask

    task automatic no_rst(input int n, input string nm);
        int h;
        h = 0;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            if (core_reset !== 1'b0) h++;
        end
        `CHK(nm, h, 0)
    endtask

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {rst, wr_stb, rd_stb, low_supply, sleep_mode} = 5'h1F;
        {wr_stb, rd_stb, low_supply, sleep_mode} = 4'h0;
        {wdt_timeout, wdt_bad_req, halt_exec, clr_wdt} = 4'h0;
        addr = 4'h0;
        wdata = 8'h00;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        wait_rst(0, 4, "por_pulse");
        chk_reg(ADDR_GUARD, GUARD_POR, "guard_por");
        chk_reg(ADDR_THRESH, THR_POR, "thr_por");
        chk_reg(ADDR_FLAGS, ZERO8, "flags_por");
        chk_reg(ADDR_STATUS, ZERO8, "status_por");
        chk_reg(ADDR_WDT_STAT, ZERO8, "seq_idle");
        chk_reg(4'h9, ZERO8, "unmapped");
        wr(ADDR_GUARD, GUARD_OK_B);
        chk_reg(ADDR_GUARD, GUARD_OK_B, "guard_rw");
        no_rst(60, "guard_ok");
        done("power_on");

        for (int k = 0; k < 5; k++) begin
            wr(ADDR_THRESH, codes[k]);
            #1;
            `CHK("level", {lvr_enable, lvr_level_sel}, {1'b1, sels[k]})
        end
        @(posedge ref_clk) sleep_mode <= 1'b1;
        @(posedge ref_clk) low_supply <= 1'b1;
        #1;
        `CHK("lvr_sleep", lvr_enable, 1'b0)
        no_rst(40, "lv_sleep");
        @(posedge ref_clk) low_supply <= 1'b0;
        sleep_mode <= 1'b0;
        wr(ADDR_THRESH, THR_OFF);
        #1;
        `CHK("lvr_off", lvr_enable, 1'b0)
        done("threshold");

        wr(ADDR_THRESH, THR_2V55);
        @(posedge ref_clk) low_supply <= 1'b1;
        no_rst(FILTER_CYC - 4, "lv_short");
        @(posedge ref_clk) low_supply <= 1'b0;
        no_rst(40, "lv_short_after");
        @(posedge ref_clk) low_supply <= 1'b1;
        wait_rst(FILTER_CYC, FILTER_CYC + 8, "lv_long");
        @(posedge ref_clk) low_supply <= 1'b0;
        chk_reg(ADDR_THRESH, THR_2V55, "thr_kept");
        chk_reg(ADDR_FLAGS, 8'h04, "lv_flag");
        wr(ADDR_FLAGS, 8'hFF);
        chk_reg(ADDR_FLAGS, 8'h04, "lv_flag_held");
        wr(ADDR_FLAGS, ZERO8);
        chk_reg(ADDR_FLAGS, ZERO8, "lv_flag_clr");
        rd(ADDR_IRQ_STAT, v);
        done("low_voltage");

        wr(ADDR_GUARD, 8'h00);
        wait_rst(SRESET_CYC - 2, SRESET_CYC + 6, "guard_delay");
        chk_reg(ADDR_GUARD, GUARD_POR, "guard_restored");
        chk_reg(ADDR_FLAGS, 8'h08, "guard_flag");
        wr(ADDR_IRQ_MASK, 8'h00);
        #1;
        i0 = irq;
        wr(ADDR_IRQ_MASK, 8'hFF);
        #1;
        i1 = irq;
        `CHK("irq_mask", {i0, i1}, 2'b01)
        chk_reg(ADDR_IRQ_MASK, 8'h1F, "mask_rw");
        chk_reg(ADDR_IRQ_STAT, 8'h08, "irq_stat");
        `CHK("irq_low", irq, 1'b0)
        chk_reg(ADDR_IRQ_STAT, ZERO8, "irq_cleared");
        wr(ADDR_FLAGS, ZERO8);
        done("guard");

        wr(ADDR_THRESH, 8'h12);
        wait_rst(SRESET_CYC - 2, SRESET_CYC + 6, "thr_delay");
        chk_reg(ADDR_THRESH, THR_POR, "thr_restore");
        chk_reg(ADDR_FLAGS, 8'h02, "thr_flag");
        wr(ADDR_FLAGS, ZERO8);
        @(posedge ref_clk) wdt_bad_req <= 1'b1;
        @(posedge ref_clk) wdt_bad_req <= 1'b0;
        wait_rst(SRESET_CYC - 2, SRESET_CYC + 6, "wdt_ctrl");
        chk_reg(ADDR_FLAGS, 8'h01, "wdt_ctrl_flag");
        wr(ADDR_FLAGS, ZERO8);
        done("faults");

        wr(ADDR_FLASH1, 8'h54);
        no_rst(10, "flash_other");
        wr(ADDR_FLASH1, FLASH_RESET_CODE);
        wait_rst(0, 4, "flash_reset");
        done("flash");

        @(posedge ref_clk) wdt_timeout <= 1'b1;
        @(posedge ref_clk) wdt_timeout <= 1'b0;
        wait_rst(0, 4, "wdt_run");
        chk_reg(ADDR_STATUS, 8'h01, "wdt_run_stat");
        @(posedge ref_clk) clr_wdt <= 1'b1;
        @(posedge ref_clk) clr_wdt <= 1'b0;
        @(posedge ref_clk) halt_exec <= 1'b1;
        @(posedge ref_clk) halt_exec <= 1'b0;
        sleep_mode <= 1'b1;
        @(posedge ref_clk) wdt_timeout <= 1'b1;
        @(posedge ref_clk) wdt_timeout <= 1'b0;
        repeat (6) begin
            @(posedge ref_clk);
            #1;
            if (pc_sp_clear === 1'b1) break;
        end
        `CHK("wake_clear", {pc_sp_clear, core_reset}, 2'b10)
        repeat (8) @(posedge ref_clk);
        chk_reg(ADDR_STATUS, 8'h03, "wake_stat");
        chk_reg(ADDR_THRESH, THR_POR, "wake_kept");
        @(posedge ref_clk) sleep_mode <= 1'b0;
        clr_wdt <= 1'b1;
        @(posedge ref_clk) clr_wdt <= 1'b0;
        chk_reg(ADDR_STATUS, ZERO8, "stat_clr");
        done("watchdog");
        end_of_test();
    end
endmodule
`default_nettype wire
